// *** core/fsbp_core.sv ***
// status register, write-enable latch and block protection of a serial flash
// assumes spi mode 0 on i_pins; sclk slow against i_ref_clk, sampled here
// Notes on behaviour
// - status reachable only via read-status and write-status commands.
// - srwd set and write-protect low make nonvolatile bits read-only.
// - only write-protect pin going high releases the hardware lock.
// - bit 7 disables status writes with the pin; default one.
// - bit 5 selects anchor; zero top, one bottom by default.
// - protect bits at 6 and 4:2 block program/erase in area.
// - write enable latch clear at reset; set by write enable.
// - bit 0 reads busy during any internal write cycle.
// - busy bit always inverse of flag status ready bit.
// - bulk erase runs only when all protect bits are zero.
// - top anchor protects doubling sector counts down from 511.
// - bottom anchor protects doubling sector counts up from 0.
// - 512 sectors of 64KB, addresses up to 01FFFFFF.
// - write-protect low still protects the selected sectors.
// - protected program or erase sets flag status protection bit.
`timescale 1ns/100ps
module fsbp_core
  import fsbp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire fsbp_pins_t i_pins,
  output logic o_miso,
  output logic o_miso_oe,
  output logic [SR_WIDTH-1:0] o_status,
  output logic o_prog_start,
  output logic o_erase_start,
  output logic [ADDR_W-1:0] o_op_addr
);
  typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA, ST_IGN} fsbp_state_t;

  fsbp_pins_t meta_r, sync_r;
  logic sclk_d_r;
  fsbp_state_t state_r;
  logic [7:0] cmd_r, shift_r, tx_r;
  logic [2:0] bitcnt_r;
  logic [4:0] bytecnt_r;
  logic [31:0] addr_r;
  fsbp_nv_t nv_r;
  logic wel_r, busy_r, prot_err_r, miso_r;
  logic [BUSY_CW-1:0] busy_cnt_r;
  logic rise, fall, byte_done, hw_lock, sect_prot, any_bp;
  logic [7:0] rx_byte, status;
  logic [3:0] block_protect_code;
  logic do_wrsr, do_prog, do_erase, do_bulk, reject;

  // two flops on every pin before use
  always_ff @(posedge i_ref_clk)
  begin
    meta_r <= i_pins;
    sync_r <= meta_r;
    sclk_d_r <= sync_r.sclk;
  end

  assign rise = sync_r.sclk & ~sclk_d_r & ~sync_r.cs_n;
  assign fall = ~sync_r.sclk & sclk_d_r & ~sync_r.cs_n;
  assign rx_byte = {shift_r[6:0], sync_r.mosi};
  assign byte_done = rise && (bitcnt_r == 3'h7);

  assign block_protect_code = {nv_r.bp3, nv_r.bp_low};
  assign any_bp = |block_protect_code;
  assign hw_lock = nv_r.srwd & ~sync_r.wp_n;
  assign status = {nv_r.srwd, nv_r.bp3, nv_r.top_bottom, nv_r.bp_low, wel_r, busy_r};

  fsbp_decode u_decode
  (
    .i_block_protect_code(block_protect_code),
    .i_bottom(nv_r.top_bottom),
    .i_sector(addr_r[SECT_LSB +: SECT_W]),
    .o_protected(sect_prot)
  );

  // commands execute on chip select rising after a complete frame
  logic cs_d_r;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      cs_d_r <= 1'b1;
    else
      cs_d_r <= sync_r.cs_n;
  end
  logic frame_end;
  assign frame_end = sync_r.cs_n & ~cs_d_r & (bitcnt_r == 3'h0) & ~busy_r;

  always_comb
  begin
    do_wrsr = 1'b0;
    do_prog = 1'b0;
    do_erase = 1'b0;
    do_bulk = 1'b0;
    reject = 1'b0;
    if (frame_end && wel_r)
    begin
      case (cmd_r)
        CMD_WRSR:
          if (bytecnt_r == 5'h2)
          begin
            if (hw_lock)
              reject = 1'b1;
            else
              do_wrsr = 1'b1;
          end
        CMD_PP:
          // command, four address bytes and at least one data byte
          if (bytecnt_r >= 5'h6)
          begin
            if (sect_prot)
              reject = 1'b1;
            else
              do_prog = 1'b1;
          end
        CMD_SE:
          if (bytecnt_r == 5'h5)
          begin
            if (sect_prot)
              reject = 1'b1;
            else
              do_erase = 1'b1;
          end
        CMD_BE:
          if (bytecnt_r == 5'h1)
          begin
            if (any_bp)
              reject = 1'b1;
            else
              do_bulk = 1'b1;
          end
        default: ;
      endcase
    end
  end

  // serial receive framing
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || sync_r.cs_n)
    begin
      state_r <= ST_CMD;
      bitcnt_r <= '0;
      if (i_rst)
      begin
        cmd_r <= '0;
        bytecnt_r <= '0;
        addr_r <= '0;
        shift_r <= '0;
      end
    end
    else if (rise)
    begin
      shift_r <= rx_byte;
      bitcnt_r <= bitcnt_r + 3'h1;
      if (byte_done)
      begin
        if (bytecnt_r != 5'h1F)
          bytecnt_r <= bytecnt_r + 5'h1;
        case (state_r)
          ST_CMD:
          begin
            cmd_r <= rx_byte;
            bytecnt_r <= 5'h1;
            state_r <= (rx_byte == CMD_PP || rx_byte == CMD_SE) ? ST_ADDR : ST_DATA;
          end
          ST_ADDR:
          begin
            addr_r <= {addr_r[23:0], rx_byte};
            if (bytecnt_r == 5'h4)
              state_r <= ST_DATA;
          end
          ST_DATA:
            if (cmd_r == CMD_WRSR && bytecnt_r == 5'h1)
              shift_r <= rx_byte;
          ST_IGN: ;
          default: state_r <= ST_IGN;
        endcase
      end
    end
  end

  // nonvolatile bits; a real part would back these with the array
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      nv_r <= fsbp_nv_t'({SR_NV_RESET[SR_SRWD_POS], SR_NV_RESET[SR_BP3_POS],
                          SR_NV_RESET[SR_TB_POS], SR_NV_RESET[SR_BPL_MSB:SR_BPL_POS]});
    else if (do_wrsr)
      nv_r <= fsbp_nv_t'({shift_r[SR_SRWD_POS], shift_r[SR_BP3_POS],
                          shift_r[SR_TB_POS], shift_r[SR_BPL_MSB:SR_BPL_POS]});
  end

  // write enable latch
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      wel_r <= 1'b0;
    else if (reject || (busy_r && busy_cnt_r == BUSY_CW'(1)))
      wel_r <= 1'b0;
    else if (frame_end && bytecnt_r == 5'h1 && cmd_r == CMD_WREN)
      wel_r <= 1'b1;
    else if (frame_end && bytecnt_r == 5'h1 && cmd_r == CMD_WRDI)
      wel_r <= 1'b0;
  end

  // busy timer for internal cycles
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
    end
    else if (do_wrsr || do_prog || do_erase || do_bulk)
    begin
      busy_r <= 1'b1;
      busy_cnt_r <= BUSY_CW'(BUSY_CYC);
    end
    else if (busy_r)
    begin
      busy_cnt_r <= busy_cnt_r - BUSY_CW'(1);
      if (busy_cnt_r == BUSY_CW'(1))
        busy_r <= 1'b0;
    end
  end

  // protection error: set wins over the clear command
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      prot_err_r <= 1'b0;
    else if (reject && cmd_r != CMD_WRSR)
      prot_err_r <= 1'b1;
    else if (frame_end && bytecnt_r == 5'h1 && cmd_r == CMD_CLFS)
      prot_err_r <= 1'b0;
  end

  // read path: byte loaded after the command byte, shifted on falling clock
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || sync_r.cs_n)
    begin
      tx_r <= '0;
      miso_r <= 1'b0;
    end
    else if (byte_done && state_r != ST_ADDR)
    begin
      if ((state_r == ST_CMD ? rx_byte : cmd_r) == CMD_RDSR)
        tx_r <= status;
      else
        tx_r <= {~busy_r, 5'h00, prot_err_r, 1'b0} & 8'hFF;
    end
    else if (fall)
    begin
      miso_r <= tx_r[7];
      tx_r <= {tx_r[6:0], tx_r[7]};
    end
  end

  assign o_miso = miso_r;
  assign o_miso_oe = ~sync_r.cs_n & (cmd_r == CMD_RDSR || cmd_r == CMD_RDFS) & (state_r == ST_DATA);
  assign o_status = status;
  assign o_prog_start = do_prog;
  assign o_erase_start = do_erase | do_bulk;
  assign o_op_addr = addr_r[ADDR_W-1:0];
endmodule : fsbp_core

// *** common/fsbp_pkg.sv ***
// package for the flash status and block-protection block
// constants, command codes, status field layout and the busy timing
package fsbp_pkg;
  // status register field positions
  localparam int unsigned SR_WIDTH = 8;
  localparam int unsigned SR_BUSY_POS = 0;
  localparam int unsigned SR_WEL_POS = 1;
  localparam int unsigned SR_BPL_POS = 2;
  localparam int unsigned SR_BPL_MSB = 4;
  localparam int unsigned SR_TB_POS = 5;
  localparam int unsigned SR_BP3_POS = 6;
  localparam int unsigned SR_SRWD_POS = 7;
  // flag status bits driven by this block
  localparam int unsigned FS_PROT_POS = 1;
  localparam int unsigned FS_READY_POS = 7;
  // nonvolatile reset: srwd=1, bottom=1, no protection
  localparam logic [7:0] SR_NV_RESET = 8'hA0;
  localparam logic [7:0] SR_NV_MASK = 8'hFC;
  // commands
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_RDFS = 8'h70;
  localparam logic [7:0] CMD_CLFS = 8'h50;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_SE = 8'hD8;
  localparam logic [7:0] CMD_BE = 8'hC7;
  // array geometry
  localparam int unsigned ADDR_W = 25;
  localparam int unsigned SECT_W = 9;
  localparam logic [24:0] ADDR_TOP = 25'h1FFFFFF;
  localparam int unsigned SUB4K_TOP = 8191;
  localparam int unsigned SECT_LSB = 16;
  // busy time of an internal cycle
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned BUSY_US = 20;
  localparam int unsigned BUSY_CYC = BUSY_US * CLK_MHZ;
  localparam int unsigned BUSY_CW = 13;

  typedef struct packed {
    logic srwd;
    logic bp3;
    logic top_bottom;
    logic [2:0] bp_low;
  } fsbp_nv_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
    logic wp_n;
  } fsbp_pins_t;
endpackage : fsbp_pkg

// *** core/fsbp_decode.sv ***
// sector protection decoder: code and anchor to protected verdict
// assumes a 9 bit 64KB sector index; purely combinational
`timescale 1ns/100ps
module fsbp_decode
  import fsbp_pkg::*;
(
  input wire logic [3:0] i_block_protect_code,
  input wire logic i_bottom,
  input wire logic [SECT_W-1:0] i_sector,
  output logic o_protected
);
  logic [SECT_W:0] count;
  logic [SECT_W-1:0] eff;

  always_comb
  begin
    // codes 10..15 saturate to the whole array
    if (i_block_protect_code == 4'h0)
      count = '0;
    else if (i_block_protect_code >= 4'hA)
      count = 10'h200;
    else
      count = 10'(10'h001 << (i_block_protect_code - 4'h1));
    // top anchor: mirror the index so both cases count from the anchor
    eff = i_bottom ? i_sector : ~i_sector;
    o_protected = ({1'b0, eff} < count);
  end
endmodule : fsbp_decode

// *** sim/fsbp_core_assertions.sv ***
// checker: timing relations at the status block ports
// assumes bind onto fsbp_core, one ref clock domain
`timescale 1ns/100ps
module fsbp_core_assertions
  import fsbp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire fsbp_pins_t i_pins,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic [SR_WIDTH-1:0] o_status,
  input wire logic o_prog_start,
  input wire logic o_erase_start,
  input wire logic [ADDR_W-1:0] o_op_addr
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [12:0] busy_cnt_r;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !o_status[SR_BUSY_POS])
      busy_cnt_r <= 13'h0;
    else
      busy_cnt_r <= busy_cnt_r + 13'h1;
  end
  // wp held low long enough to pass the pin synchroniser
  sequence s_locked;
    !i_pins.wp_n [*4] ##0 o_status[SR_SRWD_POS];
  endsequence
  sequence s_start;
    o_prog_start || o_erase_start;
  endsequence
  property p_reset_val;
    @(posedge i_ref_clk) disable iff (1'b0) i_rst |=> o_status == SR_NV_RESET;
  endproperty
  property p_lock;
    s_locked |=> $stable(o_status[7:2]);
  endproperty
  property p_nv_write;
    !$stable(o_status[7:2]) |-> o_status[SR_BUSY_POS] && $past(o_status[SR_WEL_POS]);
  endproperty
  property p_busy_wel;
    $rose(o_status[SR_BUSY_POS]) |-> $past(o_status[SR_WEL_POS]);
  endproperty
  property p_busy_len;
    $fell(o_status[SR_BUSY_POS]) |-> busy_cnt_r >= BUSY_CYC - 2 && busy_cnt_r <= BUSY_CYC + 2;
  endproperty
  property p_wel_clr;
    $fell(o_status[SR_BUSY_POS]) |-> !o_status[SR_WEL_POS];
  endproperty
  property p_start_ok;
    s_start |-> o_status[SR_WEL_POS] && !o_status[SR_BUSY_POS];
  endproperty
  property p_start_busy;
    s_start |=> o_status[SR_BUSY_POS] ##1 !(o_prog_start || o_erase_start);
  endproperty
  property p_oe_idle;
    i_pins.cs_n [*6] |-> !o_miso_oe;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("status not at reset value");
  a_lock: assert property (p_lock) else $error("status changed while locked");
  a_nv_write: assert property (p_nv_write) else $error("status changed outside a write");
  a_busy_wel: assert property (p_busy_wel) else $error("busy without write enable");
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared at end");
  a_start_ok: assert property (p_start_ok) else $error("start without latch or while busy");
  a_start_busy: assert property (p_start_busy) else $error("start not followed by busy");
  a_oe_idle: assert property (p_oe_idle) else $error("output enabled while deselected");
endmodule : fsbp_core_assertions
bind fsbp_core fsbp_core_assertions u_chk (.i_ref_clk, .i_rst, .i_pins, .o_miso, .o_miso_oe,
  .o_status, .o_prog_start, .o_erase_start, .o_op_addr);

// *** sim/fsbp_host.sv ***
// serial host model: mode 0 frames, msb first
// assumes the bench calls frame(); clock stands low between frames
`timescale 1ns/100ps
module fsbp_host
  import fsbp_pkg::*;
(
  input wire logic i_wp_n,
  input wire logic i_miso,
  output fsbp_pins_t o_pins
);
  logic sclk_r = 1'b0;
  logic mosi_r = 1'b0;
  logic cs_n_r = 1'b1;
  assign o_pins = '{sclk: sclk_r, mosi: mosi_r, cs_n: cs_n_r, wp_n: i_wp_n};
  task automatic frame(input int nb, input logic [47:0] d, output logic [7:0] r);
    r = 8'h00;
    cs_n_r = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      mosi_r = d[47-i];
      #80 sclk_r = 1'b1;
      r = {r[6:0], i_miso};
      #80 sclk_r = 1'b0;
    end
    #80 cs_n_r = 1'b1;
    // released line: no pull, so show the inverse
    mosi_r = ~mosi_r;
    #400;
  endtask : frame
endmodule : fsbp_host

// *** sim/tb_top.sv ***
// bench: protect codes, sector hits, lock pin and bulk erase
// assumes fsbp_core and the host model on its pins
`timescale 1ns/100ps
`define CHK(n, e, a) chk(n, 32'(e), 32'(a))
module tb_top;
  import fsbp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic wp_n = 1'b1;
  fsbp_pins_t pins;
  logic o_miso;
  logic o_miso_oe;
  logic o_prog_start;
  logic o_erase_start;
  logic [SR_WIDTH-1:0] o_status;
  logic [ADDR_W-1:0] o_op_addr;
  int failures = 0;
  int checks = 0;
  int n_op = 0;
  int n_oe = 0;
  logic [31:0] seed = 32'h20;
  logic [7:0] r;
  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    n_op += (o_erase_start === 1'b1) + (o_prog_start === 1'b1);
    n_oe += (o_miso_oe === 1'b1);
  end
  fsbp_core u_fsbp_core (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pins(pins), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .o_status(o_status), .o_prog_start(o_prog_start),
    .o_erase_start(o_erase_start), .o_op_addr(o_op_addr));
  fsbp_host u_fsbp_host (.i_wp_n(wp_n), .i_miso(o_miso), .o_pins(pins));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic hit(logic [7:0] v, logic [8:0] s);
    int n;
    n = ({v[6], v[4:2]} == 4'h0) ? 0 : ({v[6], v[4:2]} >= 4'hA) ? 512 : 1 << ({v[6], v[4:2]} - 1);
    return v[5] ? (s < n) : (s >= 512 - n);
  endfunction : hit
  task automatic chk(string n, logic [31:0] e, logic [31:0] a);
    checks++;
    if (a !== e)
    begin
      failures++;
      $display("FAIL %s exp %0h got %0h", n, e, a);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic tx(int nb, logic [47:0] d);
    u_fsbp_host.frame(nb, d, r);
    for (int k = 0; o_status[SR_BUSY_POS] !== 1'b0; k++)
    begin
      if (k > 5000)
      begin
        failures++;
        final_report();
      end
      @(posedge i_ref_clk);
    end
  endtask : tx
  task automatic wr_sr(logic [7:0] v);
    tx(8, {CMD_WREN, 40'h0});
    tx(16, {CMD_WRSR, v, 32'h0});
  endtask : wr_sr
  initial
  begin
    logic [31:0] t;
    logic [7:0] v;
    logic [24:0] a;
    int e0;
    repeat (10) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    `CHK("status reset", SR_NV_RESET, o_status);
    e0 = n_oe;
    tx(16, {CMD_RDSR, 40'h0});
    `CHK("status read", SR_NV_RESET, r);
    `CHK("oe on read", 1'b1, n_oe > e0);
    e0 = n_oe;
    tx(16, {CMD_WRSR, 8'h00, 32'h0});
    tx(7, {CMD_WREN, 40'h0});
    `CHK("no latch", SR_NV_RESET, o_status);
    `CHK("oe quiet", e0, n_oe);
    // two hand-picked code 9 boundaries, then random codes
    for (int i = 0; i < 5; i++)
    begin
      t = rnd();
      v = (i == 0) ? 8'h44 : (i == 1) ? 8'h64 : {1'b0, t[6:2], 2'b00};
      a = {(i < 2) ? 9'h100 : t[16:8], t[31:16]};
      wr_sr(v);
      `CHK("status nv", v, o_status);
      // pin dropped only once srwd is clear, so the code above still loads
      @(posedge i_ref_clk) #1 wp_n = t[0];
      e0 = n_op;
      tx(8, {CMD_WREN, 40'h0});
      if (i % 2)
        tx(48, {CMD_PP, 7'h0, a, t[7:0]});
      else
        tx(40, {CMD_SE, 7'h0, a, 8'h0});
      `CHK("op started", e0 + !hit(v, a[24:16]), n_op);
      `CHK("op addr", a, o_op_addr);
      `CHK("latch clr", 1'b0, o_status[SR_WEL_POS]);
      tx(16, {CMD_RDFS, 40'h0});
      `CHK("prot flag", hit(v, a[24:16]), r[FS_PROT_POS]);
      `CHK("ready inv", 1'b1, r[FS_READY_POS]);
      tx(8, {CMD_CLFS, 40'h0});
    end
    @(posedge i_ref_clk) #1 wp_n = 1'b1;
    wr_sr(8'hA4);
    @(posedge i_ref_clk) #1 wp_n = 1'b0;
    wr_sr(8'h00);
    `CHK("locked", 8'hA4, o_status & SR_NV_MASK);
    e0 = n_op;
    tx(8, {CMD_WREN, 40'h0});
    tx(8, {CMD_BE, 40'h0});
    `CHK("bulk refused", e0, n_op);
    @(posedge i_ref_clk) #1 wp_n = 1'b1;
    wr_sr(8'h00);
    `CHK("unlocked", 8'h00, o_status);
    tx(8, {CMD_WREN, 40'h0});
    tx(8, {CMD_BE, 40'h0});
    `CHK("bulk done", e0 + 1, n_op);
    final_report();
  end
endmodule : tb_top
